// File: design/indexer_pkg.sv
package indexer_pkg;

  // command codes delivered by the ascii front end after address match
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_SET_HOME_EDGE,
    CMD_SET_BACKUP,
    CMD_SET_APPROACH_DIR,
    CMD_SET_SCAN_PRESERVE,
    CMD_SET_SCAN_MODE,
    CMD_POSITION_REPORT,
    CMD_ZERO_POSITION,
    CMD_BUFFER_PAUSE,
    CMD_CONTINUE,
    CMD_VEL_PROFILE,
    CMD_INSTANT_VELOCITY,
    CMD_GO_HOME,
    CMD_MOVE_ABSOLUTE,
    CMD_STOP,
    CMD_SOFT_RESET
  } cmd_t;

  // widths
  localparam int ARG_W = 32;
  localparam int VEL_W = 16;
  localparam int POS_W = 32;

  // reset values of the setup bits
  localparam logic HOME_EDGE_DEFAULT = 1'b0;
  localparam logic BACKUP_DEFAULT = 1'b0;
  localparam logic APPROACH_DEFAULT = 1'b0;
  localparam logic SCAN_PRESERVE_DEFAULT = 1'b0;

  // signed range of the absolute counter, plus or minus 2^31 - 1
  localparam logic signed [31:0] POS_MAX = 32'sh7FFFFFFF;
  localparam logic signed [31:0] POS_MIN = -32'sh7FFFFFFF;

  // position report layout: asterisk, sign, decimal digits
  localparam int REPORT_DIGITS = 10;
  localparam logic [7:0] CHAR_STAR = 8'h2A;
  localparam logic [7:0] CHAR_PLUS = 8'h2B;
  localparam logic [7:0] CHAR_MINUS = 8'h2D;
  localparam logic [7:0] CHAR_ZERO = 8'h30;

endpackage : indexer_pkg

// File: design/position_formatter.sv
`timescale 1ns/1ps
module position_formatter
  import indexer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic signed [POS_W-1:0] value,
  output logic busy,
  // reply byte stream
  output logic reply_valid,
  output logic [7:0] reply_byte,
  input wire logic reply_ready
);

  typedef enum logic [2:0] {F_IDLE, F_STAR, F_SIGN, F_CALC, F_DIGIT} fmt_state_t;

  typedef struct packed {
    fmt_state_t state;
    logic [31:0] rem;   // magnitude still to print
    logic [3:0] idx;    // power of ten now printed
    logic [3:0] digit;  // running digit value
    logic [7:0] byte_out;
  } fmt_t;

  fmt_t st_reg;
  fmt_t st_next;

  // powers of ten for each digit place
  function automatic logic [31:0] pow10(input logic [3:0] k);
    logic [31:0] p;
    p = 32'h00000001;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(k)) begin
        p = p * 32'h0000000A;
      end
    end
    return p;
  endfunction : pow10

  // digits by repeated subtraction: slow but tiny, and replies are rare
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      F_IDLE: begin
        if (start) begin
          st_next.rem = value[POS_W-1] ? 32'(-value) : 32'(value);
          st_next.byte_out = CHAR_STAR; // [R6]
          st_next.idx = 4'(REPORT_DIGITS - 1);
          st_next.state = F_STAR;
        end
      end
      F_STAR: begin
        if (reply_ready) begin
          st_next.byte_out = value[POS_W-1] ? CHAR_MINUS : CHAR_PLUS; // [R6]
          st_next.state = F_SIGN;
        end
      end
      F_SIGN: begin
        if (reply_ready) begin
          st_next.digit = 4'h0;
          st_next.state = F_CALC;
        end
      end
      F_CALC: begin
        if (st_reg.rem >= pow10(st_reg.idx)) begin
          st_next.rem = st_reg.rem - pow10(st_reg.idx);
          st_next.digit = st_reg.digit + 4'h1;
        end else begin
          st_next.byte_out = CHAR_ZERO + {4'h0, st_reg.digit};
          st_next.state = F_DIGIT;
        end
      end
      F_DIGIT: begin
        if (reply_ready) begin
          if (st_reg.idx == 4'h0) begin
            st_next.state = F_IDLE;
          end else begin
            st_next.idx = st_reg.idx - 4'h1;
            st_next.digit = 4'h0;
            st_next.state = F_CALC;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= '{state: F_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.state != F_IDLE);
  assign reply_valid = (st_reg.state == F_STAR) || (st_reg.state == F_SIGN) ||
                       (st_reg.state == F_DIGIT);
  assign reply_byte = st_reg.byte_out;

  a_report_star: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (start && !busy) |=> (reply_valid && reply_byte == CHAR_STAR))
    else $error("report does not open with an asterisk");

endmodule : position_formatter

// File: design/home_seeker.sv
`timescale 1ns/1ps
module home_seeker
  import indexer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic home_edge_select,
  input wire logic backup_homing_enable,
  input wire logic final_approach_direction,
  // motion feedback
  input wire logic home_active,
  input wire logic motion_stopped,
  // motion requests
  output logic busy,
  output logic move_req,
  output logic move_ccw,
  output logic final_homing_velocity,
  output logic stop_req,
  output logic home_ok
);

  typedef enum logic [1:0] {H_IDLE, H_SEEK, H_DECEL, H_BACK} home_state_t;

  typedef struct packed {
    home_state_t state;
    logic home_prev; // home level one cycle ago, for edge detection
    logic ok;        // one-cycle success pulse
  } home_t;

  home_t st_reg;
  home_t st_next;
  logic hit_entry;
  logic hit_exit;
  logic stop_on_exit;

  // the selected edge is the exit edge when travelling toward its side
  assign stop_on_exit = (final_approach_direction == home_edge_select); // [R1] [R2]
  assign hit_entry = !st_reg.home_prev && home_active;
  assign hit_exit = st_reg.home_prev && !home_active;

  // seek, optional decel and back-off, declare home
  always_comb begin
    st_next = st_reg;
    st_next.home_prev = home_active;
    st_next.ok = 1'b0;
    unique case (st_reg.state)
      H_IDLE: begin
        if (start) begin
          st_next.state = H_SEEK;
        end
      end
      H_SEEK: begin
        if (home_active) begin
          if (backup_homing_enable) begin
            st_next.state = H_DECEL; // [R15]
          end else begin
            st_next.ok = 1'b1; // [R3]
            st_next.state = H_IDLE;
          end
        end
      end
      H_DECEL: begin
        if (motion_stopped) begin
          st_next.state = H_BACK;
        end
      end
      H_BACK: begin
        if (stop_on_exit ? hit_exit : hit_entry) begin
          st_next.ok = 1'b1; // [R15]
          st_next.state = H_IDLE;
        end
      end
    endcase
    if (abort) begin
      st_next.state = H_IDLE;
      st_next.ok = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= '{state: H_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.state != H_IDLE);
  assign move_req = (st_reg.state == H_SEEK) || (st_reg.state == H_BACK);
  // without back-off the seek is itself the final approach
  assign move_ccw = (st_reg.state == H_BACK || !backup_homing_enable) ?
                    final_approach_direction : !final_approach_direction; // [R16]
  assign final_homing_velocity = (st_reg.state == H_BACK); // [R15]
  assign stop_req = (st_reg.state == H_DECEL);
  assign home_ok = st_reg.ok;

  a_back_final_dir: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
    (st_reg.state == H_BACK) |-> (move_ccw == final_approach_direction && final_homing_velocity))
    else $error("back-off not in the final approach direction");

  a_no_backup_ok: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    (st_reg.state == H_SEEK && home_active && !backup_homing_enable && !abort) |=> home_ok)
    else $error("plain homing did not finish on the home level");

endmodule : home_seeker

// File: design/indexer_command_core.sv
`timescale 1ns/1ps
// Operation
// [R1] home edge select: 0 CW side, 1 CCW
// [R2] CW edge nearest CW limit, CCW likewise
// [R3] edge select only matters with back-off homing
// [R4] scan mode kept on stop only if preserve
// [R5] host guards against unintended runs after stop
// [R6] position report: asterisk, sign, decimal steps
// [R7] signed counter within 2^31-1, overrun invalidates
// [R8] zero on reset, zero command, soft reset, home
// [R9] absolute moves measured from current zero
// [R10] pause stalls execution until continue arrives
// [R11] velocity profiling entered with 1, left with 0
// [R12] profiling applies velocity directly, no ramp
// [R13] instant velocity is hex units per second
// [R14] leaving profiling mode stops the motor
// [R15] back-off: stop, reverse at final velocity, home
// [R16] final approach direction: 0 CW, 1 CCW
// [R17] sticky overflow flag, cleared when counter zeroed
module indexer_command_core
  import indexer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // decoded command in
  input wire logic cmd_valid,
  input wire cmd_t cmd_code,
  input wire logic [ARG_W-1:0] cmd_arg,
  output logic cmd_ready,
  // reply byte stream out
  output logic reply_valid,
  output logic [7:0] reply_byte,
  input wire logic reply_ready,
  // motor feedback
  input wire logic step_pulse,
  input wire logic step_ccw,
  input wire logic home_active,
  input wire logic motion_stopped,
  input wire logic stop_done,
  // setup and mode status
  output logic home_edge_select,
  output logic backup_homing_enable,
  output logic final_approach_direction,
  output logic scan_preserve_on_stop,
  output logic sequence_scan_mode,
  output logic buffer_paused,
  output logic exec_enable,
  output logic vel_profile_mode,
  // motion requests
  output logic [VEL_W-1:0] instant_velocity_command,
  output logic instant_velocity_load,
  output logic motor_stop,
  output logic move_go,
  output logic signed [POS_W-1:0] move_steps,
  output logic home_move_req,
  output logic home_move_ccw,
  output logic final_homing_velocity,
  output logic home_busy,
  // position
  output logic signed [POS_W-1:0] position_count,
  output logic position_invalid
);

  typedef struct packed {
    logic home_edge;           // home edge select setting
    logic backup;              // back-off homing setting
    logic approach;            // final approach direction setting
    logic preserve;            // keep scan mode on stop
    logic scan;                // sequence scan mode
    logic paused;              // buffer paused
    logic vel_mode;            // velocity profiling mode
    logic [VEL_W-1:0] vel;     // last instant velocity
    logic vel_load;            // one-cycle load strobe
    logic stopping;            // stop issued, waiting on completion
    logic stop_pulse;          // one-cycle stop request
    logic go_pulse;            // one-cycle move start
    logic signed [POS_W-1:0] steps;
    logic signed [POS_W-1:0] pos;
    logic invalid;             // sticky overrun flag
  } core_t;

  core_t st_reg;
  core_t st_next;
  logic cmd_take;
  logic fmt_busy;
  logic fmt_start;
  logic home_start;
  logic home_abort;
  logic home_ok;
  logic home_stop_req;
  logic zero_now;
  logic step_up;
  logic step_down;

  // reset image, also loaded by the soft reset command
  function automatic core_t reset_state();
    core_t s;
    s = '0;
    s.home_edge = HOME_EDGE_DEFAULT;
    s.backup = BACKUP_DEFAULT;
    s.approach = APPROACH_DEFAULT;
    s.preserve = SCAN_PRESERVE_DEFAULT;
    return s;
  endfunction : reset_state

  // commands that execute in order from the buffer and so obey a pause
  function automatic logic is_buffered(input cmd_t c);
    return !(c == CMD_CONTINUE || c == CMD_STOP || c == CMD_SOFT_RESET ||
             c == CMD_NOP);
  endfunction : is_buffered

  // a paused buffer holds its head; stop, reset and continue still pass
  assign cmd_ready = !fmt_busy &&
                     !(st_reg.paused && is_buffered(cmd_code)); // [R10]
  assign cmd_take = cmd_valid && cmd_ready;
  assign fmt_start = cmd_take && (cmd_code == CMD_POSITION_REPORT); // [R6]
  assign home_start = cmd_take && (cmd_code == CMD_GO_HOME);
  assign home_abort = cmd_take && (cmd_code == CMD_STOP || cmd_code == CMD_SOFT_RESET);

  // every path but rst_n that zeroes the counter; a step in the same cycle is dropped
  assign zero_now = home_ok || (cmd_take && (cmd_code == CMD_ZERO_POSITION ||
                                             cmd_code == CMD_SOFT_RESET)); // [R8]
  assign step_up = step_pulse && !step_ccw;
  assign step_down = step_pulse && step_ccw;

  // command execution and position tracking
  always_comb begin
    st_next = st_reg;
    st_next.vel_load = 1'b0;
    st_next.stop_pulse = 1'b0;
    st_next.go_pulse = 1'b0;
    if (cmd_take) begin
      unique case (cmd_code)
        CMD_SET_HOME_EDGE: st_next.home_edge = cmd_arg[0]; // [R1]
        CMD_SET_BACKUP: st_next.backup = cmd_arg[0]; // [R3]
        CMD_SET_APPROACH_DIR: st_next.approach = cmd_arg[0]; // [R16]
        CMD_SET_SCAN_PRESERVE: st_next.preserve = cmd_arg[0]; // [R4]
        CMD_SET_SCAN_MODE: st_next.scan = cmd_arg[0];
        CMD_BUFFER_PAUSE: st_next.paused = 1'b1; // [R10]
        CMD_CONTINUE: st_next.paused = 1'b0; // [R10]
        CMD_VEL_PROFILE: begin
          st_next.vel_mode = cmd_arg[0]; // [R11]
          if (!cmd_arg[0] && st_reg.vel_mode) begin
            st_next.stop_pulse = 1'b1; // [R14]
            st_next.vel = '0;
          end
        end
        CMD_INSTANT_VELOCITY: begin
          // binary value of the hex digits, units per second
          if (st_reg.vel_mode) begin
            st_next.vel = cmd_arg[VEL_W-1:0]; // [R12] [R13]
            st_next.vel_load = 1'b1; // [R12]
          end
        end
        CMD_MOVE_ABSOLUTE: begin
          // distance from here to the target, both against the current zero
          st_next.steps = $signed(cmd_arg) - st_reg.pos; // [R9]
          st_next.go_pulse = 1'b1;
        end
        CMD_STOP: begin
          st_next.stop_pulse = 1'b1;
          st_next.stopping = 1'b1; // [R4]
          st_next.vel_mode = 1'b0;
        end
        CMD_SOFT_RESET: st_next = reset_state();
        default: begin
        end
      endcase
    end
    // scan mode cleared once the stop has finished, unless preserved
    if (st_reg.stopping && stop_done) begin
      st_next.stopping = 1'b0;
      if (!st_reg.preserve) begin
        st_next.scan = 1'b0; // [R4]
      end
    end
    // position: zeroing wins over a coincident step
    if (zero_now) begin
      st_next.pos = '0; // [R8]
      st_next.invalid = 1'b0; // [R17]
    end else if (step_up) begin
      if (st_reg.pos == POS_MAX) begin
        st_next.pos = POS_MIN; // [R7]
        st_next.invalid = 1'b1; // [R17]
      end else begin
        st_next.pos = st_reg.pos + 32'sh1;
      end
    end else if (step_down) begin
      if (st_reg.pos == POS_MIN) begin
        st_next.pos = POS_MAX; // [R7]
        st_next.invalid = 1'b1; // [R17]
      end else begin
        st_next.pos = st_reg.pos - 32'sh1;
      end
    end
  end

  // state register, synchronous reset also zeroes the counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= reset_state(); // [R8]
    end else begin
      st_reg <= st_next;
    end
  end

  // decimal reply generator
  position_formatter u_formatter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(fmt_start),
    .value(st_reg.pos),
    .busy(fmt_busy),
    .reply_valid(reply_valid),
    .reply_byte(reply_byte),
    .reply_ready(reply_ready)
  );

  // homing sequencer
  home_seeker u_home (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(home_start),
    .abort(home_abort),
    .home_edge_select(st_reg.home_edge),
    .backup_homing_enable(st_reg.backup),
    .final_approach_direction(st_reg.approach),
    .home_active(home_active),
    .motion_stopped(motion_stopped),
    .busy(home_busy),
    .move_req(home_move_req),
    .move_ccw(home_move_ccw),
    .final_homing_velocity(final_homing_velocity),
    .stop_req(home_stop_req),
    .home_ok(home_ok)
  );

  // outputs
  assign home_edge_select = st_reg.home_edge;
  assign backup_homing_enable = st_reg.backup;
  assign final_approach_direction = st_reg.approach;
  assign scan_preserve_on_stop = st_reg.preserve;
  assign sequence_scan_mode = st_reg.scan;
  assign buffer_paused = st_reg.paused;
  assign exec_enable = !st_reg.paused; // [R10]
  assign vel_profile_mode = st_reg.vel_mode;
  assign instant_velocity_command = st_reg.vel;
  assign instant_velocity_load = st_reg.vel_load;
  assign motor_stop = st_reg.stop_pulse || home_stop_req;
  assign move_go = st_reg.go_pulse;
  assign move_steps = st_reg.steps;
  assign position_count = st_reg.pos;
  assign position_invalid = st_reg.invalid;

  a_zero_clears_pos: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    (cmd_take && cmd_code == CMD_ZERO_POSITION) |=> (position_count == 0 && !position_invalid))
    else $error("zero command left the counter or flag set");

  a_home_zeroes: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    home_ok |=> (position_count == 0))
    else $error("successful homing did not zero the counter");

  a_pause_holds: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    (buffer_paused && cmd_valid && cmd_code == CMD_ZERO_POSITION) |-> !cmd_ready)
    else $error("buffered command taken while paused");

  a_vel_exit_stop: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
    (cmd_take && cmd_code == CMD_VEL_PROFILE && !cmd_arg[0] && vel_profile_mode)
    |=> (motor_stop && !vel_profile_mode) ##1 !instant_velocity_load)
    else $error("leaving profiling mode did not stop the motor");

  a_vel_direct: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    (cmd_take && cmd_code == CMD_INSTANT_VELOCITY && vel_profile_mode)
    |=> (instant_velocity_load && instant_velocity_command == $past(cmd_arg[VEL_W-1:0])))
    else $error("instant velocity not applied on the next cycle");

  a_scan_cleared: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    (st_reg.stopping && stop_done && !scan_preserve_on_stop && !cmd_take) |=> !sequence_scan_mode)
    else $error("scan mode survived a stop without preserve");

  a_scan_kept: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    (st_reg.stopping && stop_done && scan_preserve_on_stop && sequence_scan_mode && !cmd_take)
    |=> sequence_scan_mode)
    else $error("scan mode lost on stop despite preserve");

  a_overrun_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
    (position_count == POS_MAX && step_up && !zero_now)
    |=> (position_invalid && position_count == POS_MIN) ##1 (position_invalid || $past(zero_now)))
    else $error("overrun not flagged or flag not sticky");

  a_abs_from_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    (cmd_take && cmd_code == CMD_MOVE_ABSOLUTE)
    |=> (move_go && move_steps == $past($signed(cmd_arg) - position_count)))
    else $error("absolute move not measured from current zero");

endmodule : indexer_command_core

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model
  import indexer_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // command side
  output logic cmd_valid,
  output cmd_t cmd_code,
  output logic [ARG_W-1:0] cmd_arg,
  input wire logic cmd_ready,
  // reply side
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte,
  output logic reply_ready
);
  // idle image; reply bytes are always welcome
  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_NOP;
    cmd_arg = 32'h00000000;
    reply_ready = 1'b1;
  end
  // offer a command at a falling edge, hold it until taken or the limit runs out
  task automatic send(input cmd_t code, input logic [ARG_W-1:0] arg, input int lim,
                      output bit ok);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_arg = arg;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1 && n < lim) begin
      n++;
      @(posedge ref_clk);
    end
    ok = (cmd_ready === 1'b1);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    // this host never starts a sequence on its own after a stop
    cmd_code = CMD_NOP;
    // stale argument is inverted so it never looks like a live value
    cmd_arg = ~arg;
  endtask : send
  // collect reply bytes under a bounded wait
  task automatic read_reply(output logic [7:0] q [12], output int got);
    got = 0;
    for (int i = 0; i < 400 && got < 12; i++) begin
      @(posedge ref_clk);
      if (reply_valid === 1'b1) begin
        q[got] = reply_byte;
        got++;
      end
    end
  endtask : read_reply
endmodule : host_model

// File: testbench/tb_indexer_command_core.sv
`timescale 1ns/1ps
module tb_indexer_command_core;
  import indexer_pkg::*;
  // bench state
  logic ref_clk, rst_n;
  int n_errors, checks_done;
  bit ok;
  // design wires
  logic cmd_valid, cmd_ready, reply_valid, reply_ready;
  cmd_t cmd_code;
  logic [ARG_W-1:0] cmd_arg;
  logic [7:0] reply_byte;
  logic step_pulse, step_ccw, home_active, motion_stopped, stop_done;
  logic home_edge_select, backup_homing_enable, final_approach_direction;
  logic scan_preserve_on_stop, sequence_scan_mode, buffer_paused, exec_enable;
  logic vel_profile_mode, instant_velocity_load, motor_stop, move_go;
  logic home_move_req, home_move_ccw, final_homing_velocity, home_busy, position_invalid;
  logic [VEL_W-1:0] instant_velocity_command;
  logic signed [POS_W-1:0] move_steps, position_count;
  // setup bits seen as one vector, in command table order
  wire [3:0] sett = {scan_preserve_on_stop, final_approach_direction,
                     backup_homing_enable, home_edge_select};
  indexer_command_core dut (.ref_clk, .rst_n, .cmd_valid, .cmd_code, .cmd_arg, .cmd_ready,
    .reply_valid, .reply_byte, .reply_ready, .step_pulse, .step_ccw, .home_active,
    .motion_stopped, .stop_done, .home_edge_select, .backup_homing_enable,
    .final_approach_direction, .scan_preserve_on_stop, .sequence_scan_mode, .buffer_paused,
    .exec_enable, .vel_profile_mode, .instant_velocity_command, .instant_velocity_load,
    .motor_stop, .move_go, .move_steps, .home_move_req, .home_move_ccw,
    .final_homing_velocity, .home_busy, .position_count, .position_invalid);
  host_model host (.ref_clk, .cmd_valid, .cmd_code, .cmd_arg, .cmd_ready, .reply_valid,
    .reply_byte, .reply_ready);
  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // one compare for every result, four-state exact
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // a command that must be taken
  task automatic cmd(input cmd_t c, input logic [31:0] a);
    host.send(c, a, 50, ok);
    chk("taken", 1, ok);
  endtask : cmd
  // motor steps, one every other cycle; ccw counts down
  task automatic steps(input int n, input logic ccw);
    repeat (n) begin
      @(negedge ref_clk);
      step_pulse = 1'b1;
      step_ccw = ccw;
      @(negedge ref_clk);
      step_pulse = 1'b0;
    end
  endtask : steps
  // request a report and judge all twelve bytes
  task automatic chk_report(input int v);
    logic [7:0] q [12];
    int got;
    int a;
    a = (v < 0) ? -v : v;
    cmd(CMD_POSITION_REPORT, 32'h00000000);
    host.read_reply(q, got);
    chk("reply count", 12, got);
    chk("star", CHAR_STAR, q[0]);
    chk("sign", (v < 0) ? CHAR_MINUS : CHAR_PLUS, q[1]);
    for (int i = 11; i >= 2; i--) begin
      chk("digit", CHAR_ZERO + a % 10, q[i]);
      a = a / 10;
    end
  endtask : chk_report
  task automatic t_settings();
    cmd_t codes [4];
    codes = '{CMD_SET_HOME_EDGE, CMD_SET_BACKUP, CMD_SET_APPROACH_DIR, CMD_SET_SCAN_PRESERVE};
    chk("defaults", {SCAN_PRESERVE_DEFAULT, APPROACH_DEFAULT, BACKUP_DEFAULT,
                     HOME_EDGE_DEFAULT}, sett);
    chk("position", 0, position_count);
    chk("profile", 0, vel_profile_mode);
    // each bit set then cleared alone, neighbours must not move
    for (int i = 0; i < 4; i++) begin
      cmd(codes[i], 32'h00000001);
      chk("settings", 4'hF >> (3 - i), sett);
    end
    for (int i = 0; i < 4; i++) begin
      cmd(codes[i], 32'h00000000);
      chk("settings", (4'hF << (i + 1)) & 4'hF, sett);
    end
    $display("test settings done");
  endtask : t_settings
  task automatic t_position();
    steps(5, 1'b0);
    steps(2, 1'b1);
    chk("position", 3, position_count);
    chk_report(3);
    steps(10, 1'b1);
    chk_report(-7);
    chk("invalid", 0, position_invalid);
    cmd(CMD_ZERO_POSITION, 32'h00000000);
    chk("position", 0, position_count);
    steps(4, 1'b0);
    cmd(CMD_MOVE_ABSOLUTE, 32'h00000064);
    chk("go", 1, move_go);
    chk("steps", 96, move_steps);
    $display("test position done");
  endtask : t_position
  task automatic t_pause();
    cmd(CMD_BUFFER_PAUSE, 32'h00000000);
    chk("paused", 1, buffer_paused);
    chk("exec", 0, exec_enable);
    host.send(CMD_ZERO_POSITION, 32'h00000000, 4, ok);
    chk("refused", 0, ok);
    chk("position", 4, position_count);
    cmd(CMD_CONTINUE, 32'h00000000);
    chk("exec", 1, exec_enable);
    cmd(CMD_ZERO_POSITION, 32'h00000000);
    chk("position", 0, position_count);
    $display("test pause done");
  endtask : t_pause
  task automatic t_profile();
    cmd(CMD_VEL_PROFILE, 32'h00000001);
    chk("profile", 1, vel_profile_mode);
    cmd(CMD_INSTANT_VELOCITY, 32'h00000100);
    chk("load", 1, instant_velocity_load);
    chk("velocity", 16'h0100, instant_velocity_command);
    cmd(CMD_VEL_PROFILE, 32'h00000000);
    chk("profile", 0, vel_profile_mode);
    chk("stop", 1, motor_stop);
    $display("test profile done");
  endtask : t_profile
  task automatic t_scan();
    for (int p = 0; p < 2; p++) begin
      cmd(CMD_SET_SCAN_PRESERVE, p);
      cmd(CMD_SET_SCAN_MODE, 32'h00000001);
      cmd(CMD_STOP, 32'h00000000);
      stop_done = 1'b1;
      @(negedge ref_clk);
      stop_done = 1'b0;
      @(negedge ref_clk);
      chk("scan", p, sequence_scan_mode);
    end
    $display("test scan done");
  endtask : t_scan
  task automatic t_home();
    // edge select 0, approach 1, no back-off: edge select has no say
    cmd(CMD_SET_APPROACH_DIR, 32'h00000001);
    steps(6, 1'b0);
    cmd(CMD_GO_HOME, 32'h00000000);
    chk("seek", 1, home_move_req);
    chk("dir", 1, home_move_ccw);
    chk("busy", 1, home_busy);
    home_active = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("position", 0, position_count);
    home_active = 1'b0;
    // back-off with edge equal to approach: stop on leaving the region
    cmd(CMD_SET_BACKUP, 32'h00000001);
    cmd(CMD_SET_HOME_EDGE, 32'h00000001);
    steps(2, 1'b0);
    cmd(CMD_GO_HOME, 32'h00000000);
    chk("seek dir", 0, home_move_ccw);
    home_active = 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk("decel", 1, motor_stop);
    motion_stopped = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("final dir", 1, home_move_ccw);
    chk("final vel", 1, final_homing_velocity);
    home_active = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("position", 0, position_count);
    motion_stopped = 1'b0;
    $display("test home done");
  endtask : t_home
  task automatic t_soft();
    steps(3, 1'b0);
    cmd(CMD_SOFT_RESET, 32'h00000000);
    @(negedge ref_clk);
    chk("settings", 0, sett);
    chk("position", 0, position_count);
    $display("test soft reset done");
  endtask : t_soft
  // main sequence, inputs settled at time zero
  initial begin
    n_errors = 0;
    checks_done = 0;
    {step_pulse, step_ccw, home_active, motion_stopped, stop_done} = 5'h00;
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    t_settings();
    t_position();
    t_pause();
    t_profile();
    t_scan();
    t_home();
    t_soft();
    summarize();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
endmodule : tb_indexer_command_core
